/* File: vector_dispatch_pkg.sv */
package vector_dispatch_pkg;

	// Program address width and the size of the vector table.
	localparam int ADDR_W = 12;
	localparam int VEC_W = 5;
	localparam int VEC_COUNT = 19;
	localparam int IRQ_COUNT = 18;
	localparam int CAUSE_COUNT = 4;

	// Reset vector number, and vector numbers at the ends of the interrupt range.
	localparam logic [VEC_W-1:0] VEC_RESET = 5'h01;
	localparam logic [VEC_W-1:0] VEC_FIRST_IRQ = 5'h02;
	localparam logic [VEC_W-1:0] VEC_LAST = 5'h13;

	// Default table addresses.
	localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;
	localparam logic [ADDR_W-1:0] ADDR_EXT_ZERO = 12'h001;
	localparam logic [ADDR_W-1:0] ADDR_EXT_ONE = 12'h002;
	localparam logic [ADDR_W-1:0] ADDR_T2_COMPARE = 12'h003;
	localparam logic [ADDR_W-1:0] ADDR_T2_OVERFLOW = 12'h004;
	localparam logic [ADDR_W-1:0] ADDR_T1_CAPTURE = 12'h005;
	localparam logic [ADDR_W-1:0] ADDR_T1_COMPARE_A = 12'h006;
	localparam logic [ADDR_W-1:0] ADDR_T1_COMPARE_B = 12'h007;
	localparam logic [ADDR_W-1:0] ADDR_T1_OVERFLOW = 12'h008;
	localparam logic [ADDR_W-1:0] ADDR_T0_OVERFLOW = 12'h009;
	localparam logic [ADDR_W-1:0] ADDR_SERIAL_XFER = 12'h00A;
	localparam logic [ADDR_W-1:0] ADDR_RX_COMPLETE = 12'h00B;
	localparam logic [ADDR_W-1:0] ADDR_TX_EMPTY = 12'h00C;
	localparam logic [ADDR_W-1:0] ADDR_TX_COMPLETE = 12'h00D;
	localparam logic [ADDR_W-1:0] ADDR_CONVERTER = 12'h00E;
	localparam logic [ADDR_W-1:0] ADDR_EEPROM_READY = 12'h00F;
	localparam logic [ADDR_W-1:0] ADDR_COMPARATOR = 12'h010;
	localparam logic [ADDR_W-1:0] ADDR_TWO_WIRE = 12'h011;
	localparam logic [ADDR_W-1:0] ADDR_SELFPROG = 12'h012;

	// Default start of the boot program section.
	localparam logic [ADDR_W-1:0] BOOT_START_DEFAULT = 12'hC00;

	// Cycles after reset before the synchronised fuse level is trusted.
	localparam logic [1:0] FUSE_SETTLE = 2'h2;

	// Dispatcher states, one-hot.
	typedef enum logic [4:0] {
		ST_WAIT = 5'h01,
		ST_IDLE = 5'h02,
		ST_LOOK = 5'h04,
		ST_LOAD = 5'h08,
		ST_ISSUE = 5'h10
	} disp_state_type;

endpackage

/* File: vec_rom_if.sv */
`timescale 1ns/10ps
interface vec_rom_if;
	import vector_dispatch_pkg::*;

	logic [VEC_W-1:0] vec_num;
	logic [ADDR_W-1:0] vec_addr;

	// The dispatcher asks by vector number; the table answers one cycle later.
	modport requester (output vec_num, input vec_addr);
	modport rom (input vec_num, output vec_addr);
endinterface

/* File: vector_rom.sv */
`timescale 1ns/10ps
module vector_rom (
	input wire logic clk_sys,
	input wire logic nrst,
	vec_rom_if.rom lookup
);
	import vector_dispatch_pkg::*;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
	} rom_reg_type;

	rom_reg_type r;
	rom_reg_type next_r;

	// Default table address for each vector number.
	always_comb begin
		next_r = r;
		case (lookup.vec_num)
			5'h01: next_r.addr = ADDR_RESET;
			5'h02: next_r.addr = ADDR_EXT_ZERO;
			5'h03: next_r.addr = ADDR_EXT_ONE;
			5'h04: next_r.addr = ADDR_T2_COMPARE;
			5'h05: next_r.addr = ADDR_T2_OVERFLOW;
			5'h06: next_r.addr = ADDR_T1_CAPTURE;
			5'h07: next_r.addr = ADDR_T1_COMPARE_A;
			5'h08: next_r.addr = ADDR_T1_COMPARE_B;
			5'h09: next_r.addr = ADDR_T1_OVERFLOW;
			5'h0A: next_r.addr = ADDR_T0_OVERFLOW;
			5'h0B: next_r.addr = ADDR_SERIAL_XFER;
			5'h0C: next_r.addr = ADDR_RX_COMPLETE;
			5'h0D: next_r.addr = ADDR_TX_EMPTY;
			5'h0E: next_r.addr = ADDR_TX_COMPLETE;
			5'h0F: next_r.addr = ADDR_CONVERTER;
			5'h10: next_r.addr = ADDR_EEPROM_READY;
			5'h11: next_r.addr = ADDR_COMPARATOR;
			5'h12: next_r.addr = ADDR_TWO_WIRE;
			5'h13: next_r.addr = ADDR_SELFPROG;
			default: next_r.addr = ADDR_RESET;
		endcase
	end

	// Read data leaves from a register.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign lookup.vec_addr = r.addr;
endmodule // vector_rom

/* File: reset_interrupt_vector_table.sv */
`timescale 1ns/10ps
// Overview of operation
// - Every reset cause fetches vector 1 at 0x000.
// - External requests go to 0x001 and 0x002.
// - Timer vectors sit at 0x003 through 0x009.
// - Serial vectors sit at 0x00A through 0x00D.
// - Remaining vectors 0x00E to 0x012, nineteen total.
// - Boot fuse moves reset start to boot section.
// - Select bit adds boot start to vectors.
// - Reset and interrupt relocation are independent.
module reset_interrupt_vector_table #(
	parameter logic [vector_dispatch_pkg::ADDR_W-1:0] BOOT_START =
		vector_dispatch_pkg::BOOT_START_DEFAULT
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [vector_dispatch_pkg::CAUSE_COUNT-1:0] reset_cause,
	input wire logic boot_reset_select_fuse,
	input wire logic vector_boot_select_bit,
	input wire logic global_irq_enable,
	input wire logic [vector_dispatch_pkg::IRQ_COUNT-1:0] irq_enable,
	input wire logic [vector_dispatch_pkg::IRQ_COUNT-1:0] irq_request,
	input wire logic fetch_ready,
	output logic fetch_valid,
	output logic [vector_dispatch_pkg::ADDR_W-1:0] fetch_addr,
	output logic [vector_dispatch_pkg::VEC_W-1:0] fetch_vector,
	output logic fetch_is_reset,
	output logic [vector_dispatch_pkg::IRQ_COUNT-1:0] irq_ack
);
	import vector_dispatch_pkg::*;

	// The relocated table must still fit the program address space, checked at elaboration.
	if (int'(BOOT_START) + int'(ADDR_SELFPROG) >= (1 << ADDR_W)) begin : g_boot_fit
		$error("BOOT_START leaves no room for the relocated table");
	end

	typedef struct packed {
		disp_state_type state;
		logic [VEC_W-1:0] vec_num;
		logic [ADDR_W-1:0] addr;
		logic is_reset;
		logic [1:0] settle;
		logic fuse_meta;
		logic fuse_sync;
		logic [IRQ_COUNT-1:0] ack;
	} disp_reg_type;

	disp_reg_type r;
	disp_reg_type next_r;
	vec_rom_if lookup ();
	logic [IRQ_COUNT-1:0] pending;

	// Adds the boot section start when relocation is asked for.
	function automatic logic [ADDR_W-1:0] relocate(input logic [ADDR_W-1:0] base,
		input logic to_boot);
		relocate = to_boot ? base + BOOT_START : base;
	endfunction

	// Index of the lowest set bit; the lowest index is the lowest vector number.
	function automatic logic [VEC_W-1:0] lowest_index(input logic [IRQ_COUNT-1:0] req);
		lowest_index = '0;
		for (int i = IRQ_COUNT - 1; i >= 0; i--) begin
			if (req[i]) begin
				lowest_index = VEC_W'(i);
			end
		end
	endfunction

	// A source just acknowledged is ignored until its flag has dropped.
	assign pending = irq_request & irq_enable & ~r.ack;

	// Dispatcher sequencing.
	always_comb begin
		next_r = r;
		next_r.fuse_meta = boot_reset_select_fuse;
		next_r.fuse_sync = r.fuse_meta;
		next_r.ack = '0;
		case (r.state)
			ST_WAIT: begin
				if (r.settle == FUSE_SETTLE) begin
					next_r.addr = relocate(ADDR_RESET, r.fuse_sync);
					next_r.vec_num = VEC_RESET;
					next_r.is_reset = 1'b1;
					next_r.state = ST_ISSUE;
				end else begin
					next_r.settle = r.settle + 2'h1;
				end
			end
			ST_IDLE: begin
				if (global_irq_enable && (|pending)) begin
					next_r.vec_num = lowest_index(pending) + VEC_FIRST_IRQ;
					next_r.is_reset = 1'b0;
					next_r.state = ST_LOOK;
				end
			end
			ST_LOOK: begin
				next_r.state = ST_LOAD;
			end
			ST_LOAD: begin
				next_r.addr = relocate(lookup.vec_addr, vector_boot_select_bit);
				next_r.state = ST_ISSUE;
			end
			ST_ISSUE: begin
				if (fetch_ready) begin
					if (!r.is_reset) begin
						next_r.ack[r.vec_num - VEC_FIRST_IRQ] = 1'b1;
					end
					next_r.state = ST_IDLE;
				end
			end
			default: begin
				next_r.state = ST_WAIT;
			end
		endcase
		// Any reset cause restarts from the reset vector.
		if (|reset_cause) begin
			next_r.state = ST_WAIT;
			next_r.settle = '0;
			next_r.ack = '0;
		end
	end

	// State register.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			r <= '{state: ST_WAIT, default: '0};
		end else begin
			r <= next_r;
		end
	end

	// The table lookup sits in its own small memory.
	vector_rom u_rom (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.lookup(lookup.rom)
	);

	// Outputs toward the core fetch logic and the peripherals.
	assign lookup.vec_num = r.vec_num;
	assign fetch_valid = (r.state == ST_ISSUE);
	assign fetch_addr = r.addr;
	assign fetch_vector = r.vec_num;
	assign fetch_is_reset = r.is_reset;
	assign irq_ack = r.ack;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	logic irq_fetch;
	logic [ADDR_W-1:0] irq_offset;
	logic [ADDR_W-1:0] table_addr;
	logic [IRQ_COUNT-1:0] lower_mask;

	// Helpers that undo relocation and mark lower-numbered sources.
	assign irq_fetch = fetch_valid && !fetch_is_reset;
	assign irq_offset = vector_boot_select_bit ? BOOT_START : '0;
	assign table_addr = fetch_addr - irq_offset;
	assign lower_mask = (IRQ_COUNT'(1) << (fetch_vector - VEC_FIRST_IRQ)) - IRQ_COUNT'(1);

	sequence s_cause_then_quiet;
		(|reset_cause) ##1 (!(|reset_cause))[*3];
	endsequence

	sequence s_irq_accept;
		irq_fetch && fetch_ready;
	endsequence

	property p_reset_fetch;
		s_cause_then_quiet |=> fetch_valid && fetch_is_reset && fetch_vector == VEC_RESET;
	endproperty
	a_reset_fetch: assert property (p_reset_fetch) else $error("reset vector not fetched");

	property p_ext_vectors;
		irq_fetch && fetch_vector <= 5'h03 |-> table_addr == ADDR_EXT_ZERO
			+ ADDR_W'(fetch_vector - VEC_FIRST_IRQ);
	endproperty
	a_ext_vectors: assert property (p_ext_vectors) else $error("external vector wrong");

	property p_timer_vectors;
		irq_fetch && fetch_vector inside {[5'h04:5'h0A]} |-> table_addr == ADDR_T2_COMPARE
			+ ADDR_W'(fetch_vector - 5'h04);
	endproperty
	a_timer_vectors: assert property (p_timer_vectors) else $error("timer vector wrong");

	property p_serial_vectors;
		irq_fetch && fetch_vector inside {[5'h0B:5'h0E]} |-> table_addr == ADDR_SERIAL_XFER
			+ ADDR_W'(fetch_vector - 5'h0B);
	endproperty
	a_serial_vectors: assert property (p_serial_vectors) else $error("serial vector wrong");

	property p_other_vectors;
		irq_fetch |-> fetch_vector <= VEC_LAST && (fetch_vector < 5'h0F
			|| table_addr == ADDR_CONVERTER + ADDR_W'(fetch_vector - 5'h0F));
	endproperty
	a_other_vectors: assert property (p_other_vectors) else $error("late vector wrong");

	property p_boot_reset;
		fetch_valid && fetch_is_reset |-> fetch_addr == (r.fuse_sync ? BOOT_START : ADDR_RESET);
	endproperty
	a_boot_reset: assert property (p_boot_reset) else $error("reset start address wrong");

	property p_irq_relocate;
		$rose(irq_fetch) && $stable(vector_boot_select_bit) |->
			fetch_addr == ADDR_W'(fetch_vector - VEC_RESET) + irq_offset;
	endproperty
	a_irq_relocate: assert property (p_irq_relocate) else $error("vector relocation wrong");

	property p_independent;
		fetch_valid && fetch_is_reset && !r.fuse_sync |-> fetch_addr == ADDR_RESET;
	endproperty
	a_independent: assert property (p_independent) else $error("select bit moved reset");

	property p_priority;
		$rose(irq_fetch) |-> ($past(pending, 3) & lower_mask) == '0;
	endproperty
	a_priority: assert property (p_priority) else $error("lower vector was skipped");

	property p_ack_pulse;
		s_irq_accept |=> irq_ack == (IRQ_COUNT'(1) << ($past(fetch_vector) - VEC_FIRST_IRQ))
			##1 irq_ack == '0;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge pulse wrong");
endmodule // reset_interrupt_vector_table

/* File: vector_peer.sv */
`timescale 1ns/10ps
module vector_peer (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [vector_dispatch_pkg::IRQ_COUNT-1:0] raise,
	input wire logic stall,
	input wire logic [vector_dispatch_pkg::IRQ_COUNT-1:0] irq_ack,
	output logic [vector_dispatch_pkg::IRQ_COUNT-1:0] irq_request,
	output logic fetch_ready
);
	import vector_dispatch_pkg::*;

	// Each flag stays pending until its acknowledge, then drops on the next edge.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			irq_request <= '0;
		end else begin
			irq_request <= (irq_request & ~irq_ack) | raise;
		end
	end

	// The core takes every offer except while it is stalled.
	assign fetch_ready = ~stall;
endmodule // vector_peer

/* File: reset_interrupt_vector_table_bench.sv */
`timescale 1ns/10ps
`define CHECK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin num_errors++; \
	$display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module reset_interrupt_vector_table_bench;
	import vector_dispatch_pkg::*;
	localparam logic [ADDR_W-1:0] BOOT = 12'h800;
	logic clk_sys, nrst, fuse, sel, gie, slow, stall, fv, fr, fir;
	logic [CAUSE_COUNT-1:0] cause;
	logic [IRQ_COUNT-1:0] en, raise, req, ack, r, e;
	logic [ADDR_W-1:0] fa;
	logic [VEC_W-1:0] fvec;
	int num_errors, total_checks, seed, cyc, i;

	reset_interrupt_vector_table #(.BOOT_START(BOOT)) reset_interrupt_vector_table_inst (
		.clk_sys(clk_sys), .nrst(nrst), .reset_cause(cause), .boot_reset_select_fuse(fuse),
		.vector_boot_select_bit(sel), .global_irq_enable(gie), .irq_enable(en),
		.irq_request(req), .fetch_ready(fr), .fetch_valid(fv), .fetch_addr(fa),
		.fetch_vector(fvec), .fetch_is_reset(fir), .irq_ack(ack));
	vector_peer vector_peer_inst (.clk_sys(clk_sys), .nrst(nrst), .raise(raise),
		.stall(stall), .irq_ack(ack), .irq_request(req), .fetch_ready(fr));

	// Clock generation.
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// The core stalls on a fixed pattern while slow mode is on.
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		stall <= #1 slow & (cyc % 3 == 1);
	end

	// Prints the counts and the verdict, then stops.
	task conclude;
		$display("errors %0d checks %0d", num_errors, total_checks);
		if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// Waits for a taken offer and compares it, then the acknowledge after it.
	task take(input logic [VEC_W-1:0] v, input logic [ADDR_W-1:0] a);
		int n;
		logic [IRQ_COUNT-1:0] oh;
		n = 0;
		oh = (v == VEC_RESET) ? '0 : (18'h1 << (v - VEC_FIRST_IRQ));
		do begin
			@(negedge clk_sys);
			n++;
		end while (!(fv === 1'b1 && fr === 1'b1) && n < 200);
		if (n >= 200) begin
			num_errors++;
			conclude();
		end else begin
			`CHECK("vector", v, fvec)
			`CHECK("address", a, fa)
			`CHECK("reset flag", v == VEC_RESET, fir)
			@(posedge clk_sys);
			#1;
			`CHECK("ack", oh, ack)
		end
	endtask

	// Expected address of an interrupt vector under the current select bit.
	function automatic logic [ADDR_W-1:0] iaddr(input int v);
		return ADDR_W'(v - 1) + (sel ? BOOT : 12'h000);
	endfunction

	// Pulses one reset cause and expects the reset offer.
	task rst_cause(input int b);
		@(posedge clk_sys);
		#1 cause = CAUSE_COUNT'(1 << b);
		@(posedge clk_sys);
		#1 cause = '0;
		take(VEC_RESET, fuse ? BOOT : ADDR_RESET);
	endtask

	// Raises a set of sources; the model queues enabled ones lowest first, then the rest.
	task service(input logic [IRQ_COUNT-1:0] rq, input logic [IRQ_COUNT-1:0] ee);
		int k;
		int v;
		int held;
		int model_q[$];
		held = 0;
		for (k = 0; k < IRQ_COUNT; k++) if (rq[k] && ee[k]) model_q.push_back(k + 2);
		for (k = 0; k < IRQ_COUNT; k++) begin
			if (rq[k] && !ee[k]) begin
				model_q.push_back(k + 2);
				held++;
			end
		end
		@(posedge clk_sys);
		#1 en = ee;
		raise = rq;
		@(posedge clk_sys);
		#1 raise = '0;
		while (model_q.size() > 0) begin
			// Held-back sources are enabled once every enabled one has been served.
			if (model_q.size() == held) en = '1;
			v = model_q.pop_front();
			take(VEC_W'(v), iaddr(v));
		end
		en = '1;
	endtask

	// Main sequence.
	initial begin
		seed = 32'h17DE;
		{nrst, fuse, sel, gie, slow, cause, en, raise} = '0;
		repeat (8) @(posedge clk_sys);
		#1 nrst = 1'b1;
		take(VEC_RESET, ADDR_RESET);
		gie = 1'b1;
		for (i = 0; i < 2 * IRQ_COUNT; i++) begin
			sel = i[0];
			service(18'h1 << (i / 2), '1);
		end
		fuse = 1'b1;
		sel = 1'b0;
		repeat (4) @(posedge clk_sys);
		for (i = 0; i < CAUSE_COUNT; i++) rst_cause(i);
		service(18'h10, '1);
		fuse = 1'b0;
		sel = 1'b1;
		repeat (4) @(posedge clk_sys);
		rst_cause(1);
		service(18'h3, '1);
		gie = 1'b0;
		raise = 18'h5;
		@(posedge clk_sys);
		#1 raise = '0;
		repeat (20) begin
			@(negedge clk_sys);
			`CHECK("idle", 1'b0, fv)
		end
		@(posedge clk_sys);
		#1 gie = 1'b1;
		take(2, iaddr(2));
		take(4, iaddr(4));
		slow = 1'b1;
		repeat (30) begin
			r = IRQ_COUNT'($random(seed));
			e = IRQ_COUNT'($random(seed));
			sel = 1'($random(seed));
			service(r, e);
		end
		conclude();
	end
endmodule // reset_interrupt_vector_table_bench
